//--- lpm_map.svh
// Functional notes
// - direct-transfer, standby, timer, low-speed, medium bits pick mode
// - wake resumes high speed, or medium when flagged; sub-sleep, and watch with low-speed set, resume sub-active
// - sub clock is watch clock over 8/4/2/1
// - new sub clock applies only after SLEEP
// - clock-stop bits 7,5,3 read zero, ignore writes
// - bit 6 low stops serial unit clock
// - serial unit registers held reset while stopped
// - bit 4 low stops converter
// - bit 2 low stops second eight-bit timer
// - bit 1 low stops flash; resets high
// - bit 0 low stops real-time clock; resets high
// - standby-select 0 sleep/sub-sleep, 1 standby/watch
// Purpose: register indices, field positions and reset values of the power block
// Assumes: register byte address is four times the register index
// Notes: definitions only
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH
`define LPM_AVS_AW 18
`define LPM_IDX_PMC1 16'hFFF0
`define LPM_IDX_PMC2 16'hFFF1
`define LPM_IDX_STAT 16'hFFF2
`define LPM_IDX_CKS1 16'hFFFA
`define LPM_PMC1_STANDBY_SELECT 7
`define LPM_PMC1_LOW_SPEED_ON 3
`define LPM_PMC1_TIMER_MODE_BIT_THREE 2
`define LPM_PMC1_MASK 8'h8C
`define LPM_PMC1_RST 8'h00
`define LPM_PMC2_DIRECT_TRANSFER_FLAG 3
`define LPM_PMC2_MEDIUM_SPEED_WAKE_FLAG 2
`define LPM_PMC2_SA_HI 1
`define LPM_PMC2_SA_LO 0
`define LPM_PMC2_MASK 8'h0F
`define LPM_PMC2_RST 8'h00
`define LPM_CKS_SERIAL 6
`define LPM_CKS_CONV 4
`define LPM_CKS_TIMER 2
`define LPM_CKS_FLASH 1
`define LPM_CKS_RTC 0
`define LPM_CKS_MASK 8'h57
`define LPM_CKS_RST 8'h03
`define LPM_SUB_DIV_BASE 4'h8
`define LPM_SA_RST 2'h0
`endif

//--- lpm_pkg.sv
// Purpose: shared types of the power block
// Assumes: code 3'b111 of the mode is never used
// Notes: constants live in lpm_map.svh
package lpm_pkg;
	// operating modes of the core, binary coded
	typedef enum logic [2:0]
	{
		pm_active_high = 3'b000,
		pm_active_med = 3'b001,
		pm_sleep = 3'b010,
		pm_standby = 3'b011,
		pm_watch = 3'b100,
		pm_subactive = 3'b101,
		pm_subsleep = 3'b110
	} power_mode_t;
endpackage : lpm_pkg

//--- lpm_mode_select.sv
// Purpose: decide where SLEEP goes and where a wake-up returns
// Assumes: mode bits are stable register outputs
// Notes: purely combinational
`timescale 1ns/1ps
module lpm_mode_select
(
	input wire lpm_pkg::power_mode_t i_mode,
	input wire logic i_standby_select,
	input wire logic i_timer_mode_bit_three,
	input wire logic i_low_speed_on,
	input wire logic i_direct_transfer_flag,
	input wire logic i_medium_speed_wake_flag,
	output lpm_pkg::power_mode_t o_sleep_mode,
	output lpm_pkg::power_mode_t o_wake_mode
);
	// active speed picked by the medium-speed flag
	wire lpm_pkg::power_mode_t active_mode = i_medium_speed_wake_flag ? lpm_pkg::pm_active_med
		: lpm_pkg::pm_active_high;
	// destination of SLEEP with the direct-transfer flag set
	wire lpm_pkg::power_mode_t direct_mode = i_low_speed_on ? lpm_pkg::pm_subactive : active_mode;
	// low-power destination: standby-select splits the two families
	wire lpm_pkg::power_mode_t stop_mode = i_timer_mode_bit_three ? lpm_pkg::pm_watch
		: lpm_pkg::pm_standby;
	wire lpm_pkg::power_mode_t doze_mode = i_low_speed_on ? lpm_pkg::pm_subsleep : lpm_pkg::pm_sleep;
	assign o_sleep_mode = i_standby_select ? stop_mode
		: (i_direct_transfer_flag ? direct_mode : doze_mode);
	// watch may resume on the sub clock, sub-sleep always does
	assign o_wake_mode = (i_mode == lpm_pkg::pm_subsleep) ? lpm_pkg::pm_subactive
		: ((i_mode == lpm_pkg::pm_watch) ? direct_mode : active_mode);
endmodule : lpm_mode_select

//--- lpm_sub_divider.sv
// Purpose: divide the watch clock into a system-clock tick
// Assumes: watch clock is far slower than the system clock
// Notes: watch clock is sampled, never used as a clock
`timescale 1ns/1ps
`include "lpm_map.svh"
module lpm_sub_divider
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_watch_clk,
	input wire logic [1:0] i_div_sel,
	output logic o_tick
);
	logic sync1_q; // first synchroniser stage
	logic sync2_q; // second synchroniser stage
	logic sync3_q; // delayed copy for edge detection
	logic [3:0] cnt_q; // watch edges counted so far
	// last count of the division, 7/3/1/0 for codes 00..11
	wire [3:0] terminal = (`LPM_SUB_DIV_BASE >> i_div_sel) - 4'h1;
	wire edge_seen = sync2_q & ~sync3_q; // rising watch edge
	// synchronise and divide
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
			cnt_q <= 4'h0;
			o_tick <= 1'b0;
		end
		else
		begin
			sync1_q <= i_watch_clk;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			o_tick <= edge_seen && (cnt_q >= terminal);
			if (edge_seen)
				cnt_q <= (cnt_q >= terminal) ? 4'h0 : cnt_q + 4'h1;
		end
	end
endmodule : lpm_sub_divider

//--- lpm_power_ctrl.sv
// Purpose: low-power mode control and peripheral clock gating
// Assumes: Avalon-MM slave, byte addresses, one wait state per access
// Notes: SLEEP and wake-up arrive as one-cycle pulses from the core
`timescale 1ns/1ps
`include "lpm_map.svh"
module lpm_power_ctrl
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	// register bus
	input wire logic [`LPM_AVS_AW-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// core events
	input wire logic i_sleep_exec,
	input wire logic i_wake_event,
	// watch clock pin, sampled
	input wire logic i_watch_clk,
	// mode outputs
	output lpm_pkg::power_mode_t o_power_mode,
	output logic o_sys_clk_run,
	output logic o_cpu_clk_run,
	output logic o_medium_speed,
	output logic o_sub_clk_tick,
	// peripheral gating
	output logic o_serial_clk_en,
	output logic o_serial_reset,
	output logic o_converter_clk_en,
	output logic o_timer_clk_en,
	output logic o_flash_clk_en,
	output logic o_realtime_clk_en
);

	// byte address of a register index
	function automatic logic [`LPM_AVS_AW-1:0] reg_addr(input logic [15:0] idx);
		reg_addr = {idx, 2'b00};
	endfunction : reg_addr

	// keep only writable bits, reserved ones stay zero
	function automatic logic [7:0] masked(input logic [7:0] wdata, input logic [7:0] mask);
		masked = wdata & mask;
	endfunction : masked

	// true in modes where the core has stopped
	function automatic logic is_low(input lpm_pkg::power_mode_t m);
		is_low = (m == lpm_pkg::pm_sleep) || (m == lpm_pkg::pm_standby)
			|| (m == lpm_pkg::pm_watch) || (m == lpm_pkg::pm_subsleep);
	endfunction : is_low

	// registers
	logic [7:0] pmc1_q; // standby-select, low-speed, timer-mode bits
	logic [7:0] pmc2_q; // direct-transfer, medium-speed, sub clock field
	logic [7:0] cks1_q; // module clock-stop bits
	logic [1:0] sub_div_q; // sub clock choice in force
	lpm_pkg::power_mode_t mode_q; // current mode
	lpm_pkg::power_mode_t mode_d; // next mode
	logic ack_q; // second cycle of a bus access
	logic [31:0] rdata_q; // read data register

	// bus decode
	wire access = i_avs_read | i_avs_write; // any request
	wire hit_pmc1 = (i_avs_address == reg_addr(`LPM_IDX_PMC1));
	wire hit_pmc2 = (i_avs_address == reg_addr(`LPM_IDX_PMC2));
	wire hit_stat = (i_avs_address == reg_addr(`LPM_IDX_STAT));
	wire hit_cks1 = (i_avs_address == reg_addr(`LPM_IDX_CKS1));
	// write lands on the edge where waitrequest is low
	wire wr_fire = i_avs_write & ack_q & i_avs_byteenable[0];
	wire [7:0] wbyte = i_avs_writedata[7:0];

	// status view: mode and sub clock in force
	wire [7:0] status_byte = {2'b00, sub_div_q, 1'b0, mode_q};

	// read mux; unmapped addresses return zero
	wire [7:0] rd_byte = hit_pmc1 ? pmc1_q
		: hit_pmc2 ? pmc2_q
		: hit_cks1 ? cks1_q
		: hit_stat ? status_byte
		: 8'h00;

	// mode bits as named wires
	wire standby_select = pmc1_q[`LPM_PMC1_STANDBY_SELECT];
	wire low_speed_on = pmc1_q[`LPM_PMC1_LOW_SPEED_ON];
	wire timer_mode_bit_three = pmc1_q[`LPM_PMC1_TIMER_MODE_BIT_THREE];
	wire direct_transfer_flag = pmc2_q[`LPM_PMC2_DIRECT_TRANSFER_FLAG];
	wire medium_speed_wake_flag = pmc2_q[`LPM_PMC2_MEDIUM_SPEED_WAKE_FLAG];
	wire [1:0] subactive_clock_sel = {pmc2_q[`LPM_PMC2_SA_HI], pmc2_q[`LPM_PMC2_SA_LO]};

	// destinations offered by the selector
	lpm_pkg::power_mode_t sleep_target; // where SLEEP goes
	lpm_pkg::power_mode_t wake_target; // where a wake-up returns

	// SLEEP accepted only while the core is running
	wire sleep_go = i_sleep_exec & ~is_low(mode_q);
	// wake-up accepted only in a stopped mode
	wire wake_go = i_wake_event & is_low(mode_q);

	// mode selection
	lpm_mode_select u_select
	(
		.i_mode(mode_q),
		.i_standby_select(standby_select),
		.i_timer_mode_bit_three(timer_mode_bit_three),
		.i_low_speed_on(low_speed_on),
		.i_direct_transfer_flag(direct_transfer_flag),
		.i_medium_speed_wake_flag(medium_speed_wake_flag),
		.o_sleep_mode(sleep_target),
		.o_wake_mode(wake_target)
	);

	// watch clock divider on the sub clock choice in force
	lpm_sub_divider u_divider
	(
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_watch_clk(i_watch_clk),
		.i_div_sel(sub_div_q),
		.o_tick(o_sub_clk_tick)
	);

	// next mode: SLEEP from a running mode, wake from a stopped one
	always_comb
	begin
		mode_d = mode_q;
		unique case (mode_q)
			lpm_pkg::pm_active_high,
			lpm_pkg::pm_active_med,
			lpm_pkg::pm_subactive:
			begin
				// running: only SLEEP moves us
				if (sleep_go)
					mode_d = sleep_target;
			end
			lpm_pkg::pm_sleep,
			lpm_pkg::pm_standby,
			lpm_pkg::pm_watch,
			lpm_pkg::pm_subsleep:
			begin
				// stopped: only a wake-up moves us
				if (wake_go)
					mode_d = wake_target;
			end
			default:
			begin
				// illegal code recovers to full speed
				mode_d = lpm_pkg::pm_active_high;
			end
		endcase
	end

	// bus handshake: one wait cycle, then the answer
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			ack_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end
		else
		begin
			ack_q <= access & ~ack_q;
			// data captured in the wait cycle, shown in the answer cycle
			if (i_avs_read && !ack_q)
				rdata_q <= {24'h000000, rd_byte};
		end
	end

	// first control register, own bits only
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			pmc1_q <= `LPM_PMC1_RST;
		else if (wr_fire && hit_pmc1)
			pmc1_q <= masked(wbyte, `LPM_PMC1_MASK);
	end

	// second control register
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			pmc2_q <= `LPM_PMC2_RST;
		else if (wr_fire && hit_pmc2)
			pmc2_q <= masked(wbyte, `LPM_PMC2_MASK);
	end

	// clock-stop register; reserved bits cannot be set
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			cks1_q <= `LPM_CKS_RST;
		else if (wr_fire && hit_cks1)
			cks1_q <= masked(wbyte, `LPM_CKS_MASK);
	end

	// sub clock choice copied only when SLEEP executes
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			sub_div_q <= `LPM_SA_RST;
		else if (sleep_go)
			sub_div_q <= subactive_clock_sel;
	end

	// mode register
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			mode_q <= lpm_pkg::pm_active_high;
		else
			mode_q <= mode_d;
	end

	// bus outputs
	assign o_avs_waitrequest = access & ~ack_q;
	assign o_avs_readdata = rdata_q;

	// mode outputs, all from the mode register
	assign o_power_mode = mode_q;
	// system oscillator runs in active and sleep modes
	assign o_sys_clk_run = (mode_q == lpm_pkg::pm_active_high) || (mode_q == lpm_pkg::pm_active_med)
		|| (mode_q == lpm_pkg::pm_sleep);
	// core executes in active and sub-active modes
	assign o_cpu_clk_run = ~is_low(mode_q);
	// medium-speed active
	assign o_medium_speed = (mode_q == lpm_pkg::pm_active_med);

	// gating outputs, straight from the clock-stop bits
	assign o_serial_clk_en = cks1_q[`LPM_CKS_SERIAL];
	// serial unit held in reset while its clock is stopped
	assign o_serial_reset = ~cks1_q[`LPM_CKS_SERIAL];
	assign o_converter_clk_en = cks1_q[`LPM_CKS_CONV];
	assign o_timer_clk_en = cks1_q[`LPM_CKS_TIMER];
	// software must keep this set while an emulator is attached
	assign o_flash_clk_en = cks1_q[`LPM_CKS_FLASH];
	assign o_realtime_clk_en = cks1_q[`LPM_CKS_RTC];

endmodule : lpm_power_ctrl

//--- lpm_power_ctrl_monitor.sv
// Purpose: port checks of the power block
// Assumes: one clock, one wait state per bus access
// Notes: bound to every lpm_power_ctrl instance
`timescale 1ns/1ps
`include "lpm_map.svh"
module lpm_power_ctrl_chk
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic [`LPM_AVS_AW-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic i_sleep_exec,
	input wire logic i_wake_event,
	input wire lpm_pkg::power_mode_t o_power_mode,
	input wire logic o_cpu_clk_run,
	input wire logic o_serial_clk_en,
	input wire logic o_serial_reset,
	input wire logic o_converter_clk_en,
	input wire logic o_timer_clk_en,
	input wire logic o_flash_clk_en,
	input wire logic o_realtime_clk_en
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);
	// write into the clock-stop register completing at this edge
	wire cks_wr = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] && i_avs_address == 18'h3FFE8;
	// all gate outputs together
	wire [4:0] gates = {o_serial_clk_en, o_converter_clk_en, o_timer_clk_en, o_flash_clk_en, o_realtime_clk_en};
	wait_first_a: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
		else $error("request not held for a wait state");
	wait_one_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("wait state longer than one cycle");
	rsv_zero_a: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address == 18'h3FFE8 |-> !(|(o_avs_readdata[7:0] & 8'hA8)))
		else $error("reserved clock-stop bit read as one");
	serial_set_a: assert property (cks_wr |=> o_serial_clk_en == $past(i_avs_writedata[6]))
		else $error("serial enable does not follow write");
	conv_timer_a: assert property (cks_wr |=> {o_converter_clk_en, o_timer_clk_en} == $past({i_avs_writedata[4], i_avs_writedata[2]}))
		else $error("converter or timer enable does not follow write");
	flash_rtc_a: assert property (cks_wr |=> {o_flash_clk_en, o_realtime_clk_en} == $past(i_avs_writedata[1:0]))
		else $error("flash or rtc enable does not follow write");
	serial_rst_a: assert property (o_serial_reset == !o_serial_clk_en)
		else $error("serial reset not tied to its standby");
	gate_hold_a: assert property (!$stable(gates) |-> $past(cks_wr))
		else $error("gate changed without a write");
	// direct transfer may land in a running mode, so only the cpu clock must agree with the new mode
	sleep_go_a: assert property (i_sleep_exec && o_power_mode == lpm_pkg::pm_active_high
		|=> o_cpu_clk_run == (o_power_mode inside {lpm_pkg::pm_active_high, lpm_pkg::pm_active_med,
		lpm_pkg::pm_subactive}))
		else $error("cpu clock does not match the mode after sleep");
	wake_run_a: assert property (i_wake_event && o_power_mode inside {lpm_pkg::pm_sleep, lpm_pkg::pm_standby}
		|=> o_power_mode inside {lpm_pkg::pm_active_high, lpm_pkg::pm_active_med})
		else $error("wake did not return to an active mode");
	cks_wr_c: cover property (cks_wr);
	sleep_c: cover property (i_sleep_exec ##1 !o_cpu_clk_run);
	wake_c: cover property (i_wake_event ##1 o_cpu_clk_run);
endmodule : lpm_power_ctrl_chk
bind lpm_power_ctrl lpm_power_ctrl_chk u_lpm_power_ctrl_chk (.i_clk, .i_arst_n, .i_avs_address, .i_avs_read,
	.i_avs_write, .i_avs_byteenable, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_sleep_exec,
	.i_wake_event, .o_power_mode, .o_cpu_clk_run, .o_serial_clk_en, .o_serial_reset, .o_converter_clk_en,
	.o_timer_clk_en, .o_flash_clk_en, .o_realtime_clk_en);

//--- lpm_power_ctrl_bench.sv
// Purpose: self-checking bench of the power block
// Assumes: bus answers after waitrequest falls
// Notes: watch clock period is eight system cycles
`timescale 1ns/1ps
`include "lpm_map.svh"
module lpm_power_ctrl_bench;
	localparam logic [17:0] a_c1 = {`LPM_IDX_PMC1, 2'b00};
	localparam logic [17:0] a_c2 = {`LPM_IDX_PMC2, 2'b00};
	localparam logic [17:0] a_st = {`LPM_IDX_STAT, 2'b00};
	localparam logic [17:0] a_ck = {`LPM_IDX_CKS1, 2'b00};
	logic i_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [`LPM_AVS_AW-1:0] i_avs_address = '0;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [3:0] i_avs_byteenable = 4'h0;
	logic [31:0] i_avs_writedata = 32'h0;
	logic i_sleep_exec = 1'b0;
	logic i_wake_event = 1'b0;
	logic [2:0] wdiv = 3'h0; // watch clock phase
	logic [31:0] o_avs_readdata;
	logic o_avs_waitrequest, o_sys_clk_run, o_cpu_clk_run, o_medium_speed, o_sub_clk_tick;
	logic o_serial_clk_en, o_serial_reset, o_converter_clk_en, o_timer_clk_en, o_flash_clk_en, o_realtime_clk_en;
	lpm_pkg::power_mode_t o_power_mode;
	logic [7:0] rdv; // last read byte
	int error_cnt = 0;
	int samples_checked = 0;
	wire i_watch_clk = wdiv[2];
	// gate outputs at their register bit positions
	wire [7:0] gates = {1'b0, o_serial_clk_en, 1'b0, o_converter_clk_en, 1'b0, o_timer_clk_en, o_flash_clk_en,
		o_realtime_clk_en};
	lpm_power_ctrl u_lpm_power_ctrl (.i_clk, .i_arst_n, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_byteenable,
		.i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_sleep_exec, .i_wake_event, .i_watch_clk,
		.o_power_mode, .o_sys_clk_run, .o_cpu_clk_run, .o_medium_speed, .o_sub_clk_tick, .o_serial_clk_en,
		.o_serial_reset, .o_converter_clk_en, .o_timer_clk_en, .o_flash_clk_en, .o_realtime_clk_en);
	// system clock
	always #2.5 i_clk = ~i_clk;
	// watch clock divider, stepped on the system clock
	always @(posedge i_clk)
		wdiv <= wdiv + 3'h1;
	// compare and count
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// one bus access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] d, input logic [3:0] b);
		logic busy;
		@(posedge i_clk);
		i_avs_address <= a;
		i_avs_writedata <= {24'h0, d};
		i_avs_byteenable <= b;
		i_avs_write <= w;
		i_avs_read <= !w;
		busy = 1'b1;
		while (busy)
		begin
			@(negedge i_clk);
			busy = (o_avs_waitrequest !== 1'b0);
			rdv = o_avs_readdata[7:0];
			@(posedge i_clk);
		end
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
		@(negedge i_clk);
	endtask : bus
	// one-cycle sleep or wake pulse
	task automatic pulse(input logic s);
		@(posedge i_clk);
		i_sleep_exec <= s;
		i_wake_event <= !s;
		@(posedge i_clk);
		i_sleep_exec <= 1'b0;
		i_wake_event <= 1'b0;
		@(negedge i_clk);
	endtask : pulse
	// cycles until the next sub clock tick
	task automatic next_tick(output int n);
		n = 0;
		do
		begin
			@(negedge i_clk);
			n++;
		end
		while (o_sub_clk_tick !== 1'b1 && n < 300);
	endtask : next_tick
	// reset values and an unmapped read
	task automatic t_reset;
		chk("gates", 8'h03, gates);
		bus(1'b0, a_ck, 8'h00, 4'h1);
		chk("cks", 8'h03, rdv);
		bus(1'b0, 18'h00000, 8'h00, 4'h1);
		chk("unmapped", 8'h00, rdv);
	endtask : t_reset
	// gate patterns, reserved bits, lane-off write
	task automatic t_gates;
		logic [7:0] p [5] = '{8'hFF, 8'h00, 8'hA8, 8'h14, 8'h57};
		foreach (p[i])
		begin
			bus(1'b1, a_ck, p[i], 4'h1);
			chk("gates", p[i] & 8'h57, gates);
			chk("serial_reset", {7'h0, !p[i][6]}, {7'h0, o_serial_reset});
			bus(1'b0, a_ck, 8'h00, 4'h1);
			chk("cks", p[i] & 8'h57, rdv);
		end
		bus(1'b1, a_ck, 8'h00, 4'h0);
		chk("gates", 8'h57, gates);
		// flash gate left set, as an attached emulator needs
		bus(1'b1, a_ck, 8'h03, 4'h1);
	endtask : t_gates
	// mode table: ctrl1, ctrl2, mode after sleep, mode after wake
	task automatic t_modes;
		logic [7:0] c1 [8] = '{8'h00, 8'h00, 8'h80, 8'h84, 8'h08, 8'h00, 8'h08, 8'h00};
		logic [7:0] c2 [8] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h08, 8'h08, 8'h00};
		logic [2:0] ms [8] = '{3'h2, 3'h2, 3'h3, 3'h4, 3'h6, 3'h0, 3'h5, 3'h2};
		logic [2:0] mw [8] = '{3'h0, 3'h1, 3'h0, 3'h0, 3'h5, 3'h0, 3'h5, 3'h0};
		foreach (c1[i])
		begin
			bus(1'b1, a_c1, c1[i], 4'h1);
			bus(1'b1, a_c2, c2[i], 4'h1);
			pulse(1'b1);
			chk("sleep_mode", {5'h0, ms[i]}, {5'h0, o_power_mode});
			chk("sys_run", {7'h0, ms[i] <= 3'h2}, {7'h0, o_sys_clk_run});
			pulse(1'b0);
			chk("wake_mode", {5'h0, mw[i]}, {5'h0, o_power_mode});
			chk("medium", {7'h0, mw[i] == 3'h1}, {7'h0, o_medium_speed});
		end
	endtask : t_modes
	// sub clock divider switches only at sleep
	task automatic t_sub;
		int n;
		for (int c = 0; c < 4; c++)
		begin
			bus(1'b1, a_c2, c[7:0], 4'h1);
			bus(1'b0, a_st, 8'h00, 4'h1);
			chk("div_before", (c == 0) ? 8'h00 : 8'(c - 1), {6'h0, rdv[5:4]});
			pulse(1'b1);
			bus(1'b0, a_st, 8'h00, 4'h1);
			chk("div_after", c[7:0], {6'h0, rdv[5:4]});
			next_tick(n);
			next_tick(n);
			next_tick(n);
			chk("tick_gap", 8'd64 >> c, n[7:0]);
			pulse(1'b0);
		end
	endtask : t_sub
	// verdict and end of run
	task automatic end_of_test;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	// hang guard, far beyond the expected run
	initial
	begin
		#100000;
		error_cnt++;
		end_of_test();
	end
	// main sequence
	initial
	begin
		repeat (3) @(posedge i_clk);
		i_arst_n <= 1'b1;
		@(negedge i_clk);
		t_reset();
		t_gates();
		t_modes();
		t_sub();
		end_of_test();
	end
endmodule : lpm_power_ctrl_bench
